// ==== hw/sbs_pkg.sv ====
/*
  Shared constants, types and helpers of the secure byte-wide bus select block.
  Assumes one clock, clk_sys at 250 MHz, and an APB master with 32-bit data.

// Functional notes
// [RULE1] Fourth RAM select decodes a fourth 32k block when size select is high.
// [RULE2] In 128k mode the third RAM select carries address bit 15.
// [RULE3] In 128k mode the second RAM select carries address bit 16.
// [RULE4] Backed RAM selects stay high while running from the backup cell.
// [RULE5] Peripheral select 0 covers data 0000h-3FFFh when peripheral space is on.
// [RULE6] Peripheral select 1 covers data 4000h-7FFFh when peripheral space is on.
// [RULE7] Peripheral select 2 covers data 8000h-BFFFh when peripheral space is on.
// [RULE8] Peripheral select 3 covers data C000h-FFFFh when peripheral space is on.
// [RULE9] Loader trigger falling edge, or low at power-up, starts the loader.
// [RULE10] The outside debounces the loader trigger to one falling edge.
// [RULE11] Drive the open-drain power reset line low while supply is too low.
// [RULE12] Power reset line pulled low from outside resets the device.
// [RULE13] Backup indicator goes low while running from the backup cell.
// [RULE14] Size select high means 32k SRAMs, low means one 128k SRAM.
// [RULE15] Tamper erase high destroys vector RAM, keys and the backed supply.
// [RULE16] Tamper erase acts like clearing the lock, erasing key and 48-byte RAM.
// [RULE17] The outside ties tamper erase low when no tamper circuit exists.
// [RULE18] An unbacked copy of RAM select A ignores backup operation.
// [RULE19] Bus traffic is encrypted with a 64-bit protected key.
// [RULE20] The key loads only from the on-chip random source.
// [RULE21] The byte-wide bus reaches up to 128kB of SRAM.
// [RULE22] Any attempt to reach the key erases it.
// [RULE23] Write strobe is suppressed for blocks partitioned as program space.
// [RULE24] RAM select A is the primary decoded chip enable.
// [RULE25] With peripheral space off no peripheral select asserts; SRAM is used.
*/
package sbs_pkg;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_KEY    = 8'h08;
  localparam logic [7:0] OFF_VIDX   = 8'h0C;
  localparam logic [7:0] OFF_VDATA  = 8'h10;

  localparam int CTRL_PSPACE   = 0;
  localparam int CTRL_LOCK     = 1;
  localparam int CTRL_KLOAD    = 2;
  localparam int CTRL_PART_LSB = 8;
  localparam int ST_SIZE       = 0;
  localparam int ST_BACKUP     = 1;
  localparam int ST_KEY_LSB    = 2;
  localparam int ST_TAMPER     = 4;
  localparam int ST_LOADER     = 5;

  localparam logic [7:0] PART_RST   = 8'h00;
  localparam logic       PSPACE_RST = 1'b0;

  localparam int KEY_BITS  = 64;
  localparam int VEC_DEPTH = 48;
  localparam int VEC_AW    = 6;
  localparam int MEM_AW    = 17;
  localparam int BUS_AW    = 15;

  typedef enum logic [1:0]
  {
    KEY_EMPTY  = 2'b00,
    KEY_LOADED = 2'b01,
    KEY_LOCKED = 2'b11
  } sbs_key_e;

  typedef struct packed
  {
    logic              valid;
    logic              data_space;
    logic              write;
    logic [MEM_AW-1:0] addr;
    logic [7:0]        wdata;
  } sbs_mem_req_s;

  typedef struct packed
  {
    logic [3:0] ram_n;
    logic [3:0] periph_n;
    logic       wr_n;
  } sbs_sel_s;

  function automatic logic [7:0] key_byte(input logic [KEY_BITS-1:0] key,
                                          input logic [2:0] idx);
    key_byte = key[{idx, 3'h0} +: 8];
  endfunction

endpackage

// ==== hw/sbs_fall_detect.sv ====
/*
  Falling edge detector for an active-low request level.
  Assumes the level is already synchronous to clk_sys.
*/
`timescale 1ns/10ps
module sbs_fall_detect
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // Level and event
  input  wire logic level_n,
  output wire logic fall
);
  logic prev;

  // Reset high, so a level already low after reset counts as an edge
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      prev <= 1'b1;
    else
      prev <= level_n;
  end

  assign fall = prev & ~level_n; // RULE9
endmodule

// ==== hw/sbs_bus_decode.sv ====
/*
  Combinational chip enable and write strobe decode for the byte-wide bus.
  Assumes a registered request and registers its outputs downstream.
*/
`timescale 1ns/10ps
module sbs_bus_decode
(
  // Request and configuration
  input  wire sbs_pkg::sbs_mem_req_s req,
  input  wire logic                  size_sel,
  input  wire logic                  periph_space_sel,
  input  wire logic [7:0]            partition,
  // Decoded selects, active low
  output sbs_pkg::sbs_sel_s          sel
);
  wire       periph_hit = req.valid & req.data_space & periph_space_sel;
  wire       ram_hit    = req.valid & ~periph_hit; // RULE25
  wire [1:0] blk        = req.addr[16:15];
  wire [1:0] quad       = req.addr[15:14];
  wire       is_code    = req.addr[16:9] < partition;
  wire [3:0] ram32_n    = ~(4'(ram_hit) << blk); // RULE1 RULE24
  wire [3:0] ram128_n   = {1'b1, req.addr[15], req.addr[16], ~ram_hit}; // RULE2 RULE3
  wire [3:0] periph_n   = ~(4'(periph_hit) << quad); // RULE5 RULE6 RULE7 RULE8
  wire       wr_ok      = req.valid & req.write & (periph_hit | ~is_code); // RULE23

  assign sel.ram_n    = size_sel ? ram32_n : ram128_n; // RULE14 RULE21
  assign sel.periph_n = periph_n;
  assign sel.wr_n     = ~wr_ok;
endmodule

// ==== hw/sbs_bus_select.sv ====
/*
  Secure byte-wide bus select: chip enables, peripheral enables, write strobe,
  power reset line, backup indicator, loader trigger, tamper erase, key and
  vector RAM with an APB register port.
  Assumes all inputs are synchronous to clk_sys and the core presents one
  registered memory request per cycle.
*/
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
module sbs_bus_select
(
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic                           pready,
  output logic [31:0]                    prdata,
  output logic                           pslverr,
  // Core memory request
  input  wire sbs_pkg::sbs_mem_req_s     mem_req,
  output logic [7:0]                     mem_rdata,
  // Byte-wide bus
  output logic [sbs_pkg::BUS_AW-1:0]     byte_bus_addr,
  output logic [7:0]                     byte_bus_data_out,
  output logic                           byte_bus_data_oe,
  input  wire logic [7:0]                byte_bus_data_in,
  output logic                           mem_write_n,
  output logic                           ram_select_a,
  output logic                           ram_select_b,
  output logic                           ram_select_c,
  output logic                           ram_select_d,
  output logic                           ram_select_a_unbacked,
  output logic                           periph_select_0,
  output logic                           periph_select_1,
  output logic                           periph_select_2,
  output logic                           periph_select_3,
  // Power
  input  wire logic                      vcc_low,
  input  wire logic                      vcc_backup,
  input  wire logic                      power_reset_in,
  output logic                           power_reset_out,
  output logic                           power_reset_oe,
  output logic                           core_reset_n,
  output logic                           backup_active_n,
  output logic                           vcco_enable,
  // Security and straps
  input  wire logic                      sram_size_sel,
  input  wire logic                      loader_trigger_n,
  output logic                           loader_start,
  input  wire logic                      tamper_erase_in,
  input  wire logic [sbs_pkg::KEY_BITS-1:0] trng_data,
  input  wire logic                      trng_valid
);

  // Configuration and state
  logic                          periph_space_sel;
  logic [7:0]                    partition;
  logic [sbs_pkg::KEY_BITS-1:0]  key;
  sbs_pkg::sbs_key_e             key_state;
  sbs_pkg::sbs_key_e             next_key_state;
  logic                          tamper_seen;
  logic                          loader_seen;
  logic [sbs_pkg::VEC_AW-1:0]    vec_idx;
  logic [7:0]                    vec_mem [sbs_pkg::VEC_DEPTH];
  sbs_pkg::sbs_mem_req_s         req_q;
  logic                          rd_pending;
  logic [2:0]                    rd_key_idx;
  sbs_pkg::sbs_sel_s             sel;
  wire                           loader_fall;

  // APB access decode; one wait state so prdata can come from a flop
  wire acc      = psel & penable & ~pready;
  wire wr_en    = acc & pwrite;
  wire rd_en    = acc & ~pwrite;
  wire hit_ctrl = paddr == sbs_pkg::OFF_CTRL;
  wire hit_st   = paddr == sbs_pkg::OFF_STATUS;
  wire hit_key  = paddr == sbs_pkg::OFF_KEY;
  wire hit_vidx = paddr == sbs_pkg::OFF_VIDX;
  wire hit_vdat = paddr == sbs_pkg::OFF_VDATA;
  wire hit_any  = hit_ctrl | hit_st | hit_key | hit_vidx | hit_vdat;

  // Security events
  wire locked    = key_state == sbs_pkg::KEY_LOCKED;
  wire key_probe = acc & hit_key; // RULE22
  wire lock_clr  = wr_en & hit_ctrl & locked & ~pwdata[sbs_pkg::CTRL_LOCK];
  wire erase     = tamper_erase_in | key_probe | lock_clr; // RULE16
  wire lock_set  = wr_en & hit_ctrl & pwdata[sbs_pkg::CTRL_LOCK];
  wire key_load  = wr_en & hit_ctrl & pwdata[sbs_pkg::CTRL_KLOAD] & trng_valid;
  wire vec_in    = vec_idx < sbs_pkg::VEC_AW'(sbs_pkg::VEC_DEPTH);
  wire vec_wr    = wr_en & hit_vdat & ~locked & vec_in;

  // Power and reset
  wire rst_req   = vcc_low | ~power_reset_in; // RULE12
  wire hold_high = vcc_backup | rst_req; // RULE4

  // Read data selection
  wire [31:0] ctrl_rd = {16'h0000, partition, 6'h00, locked, periph_space_sel};
  wire [31:0] st_rd   = {26'h0000000, loader_seen, tamper_seen, key_state,
                         vcc_backup, sram_size_sel};
  wire [7:0]  vec_rd  = (vec_in & ~locked) ? vec_mem[vec_idx] : 8'h00;
  wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd :
                        hit_st   ? st_rd :
                        hit_vidx ? {26'h0000000, vec_idx} :
                        hit_vdat ? {24'h000000, vec_rd} :
                                   32'h00000000;

  // Key state machine; erase always wins
  always_comb
  begin
    next_key_state = key_state;
    case (key_state)
      sbs_pkg::KEY_EMPTY:
        if (key_load)
          next_key_state = sbs_pkg::KEY_LOADED;
      sbs_pkg::KEY_LOADED:
        if (lock_set)
          next_key_state = sbs_pkg::KEY_LOCKED;
      sbs_pkg::KEY_LOCKED:
        next_key_state = sbs_pkg::KEY_LOCKED;
      default:
        next_key_state = sbs_pkg::KEY_EMPTY;
    endcase
    if (erase)
      next_key_state = sbs_pkg::KEY_EMPTY;
  end

  sbs_bus_decode u_decode
  (
    .req              (req_q),
    .size_sel         (sram_size_sel),
    .periph_space_sel (periph_space_sel),
    .partition        (partition),
    .sel              (sel)
  );

  sbs_fall_detect u_loader
  (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .level_n (loader_trigger_n),
    .fall    (loader_fall)
  );

  // APB slave outputs
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= acc;
      pslverr <= acc & ~hit_any;
      prdata  <= rd_en ? rd_mux : 32'h00000000;
    end
  end

  // Control register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      periph_space_sel <= sbs_pkg::PSPACE_RST;
      partition        <= sbs_pkg::PART_RST;
    end
    else if (wr_en & hit_ctrl)
    begin
      periph_space_sel <= pwdata[sbs_pkg::CTRL_PSPACE];
      partition        <= pwdata[sbs_pkg::CTRL_PART_LSB +: 8];
    end
  end

  // Key storage; only the random source can fill it
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      key_state <= sbs_pkg::KEY_EMPTY;
    else
      key_state <= next_key_state;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      key <= '0;
    else if (erase)
      key <= '0; // RULE15 RULE16 RULE22
    else if (key_load & ~locked)
      key <= trng_data; // RULE20
  end

  // Vector RAM; cleared in one cycle on erase
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      vec_idx <= '0;
    else if (wr_en & hit_vidx)
      vec_idx <= pwdata[sbs_pkg::VEC_AW-1:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (erase)
    begin
      for (int i = 0; i < sbs_pkg::VEC_DEPTH; i++)
        vec_mem[i] <= 8'h00; // RULE16
    end
    else if (vec_wr)
      vec_mem[vec_idx] <= pwdata[7:0];
  end

  // Sticky status; a new event wins over a write-one clear
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      tamper_seen <= 1'b0;
      loader_seen <= 1'b0;
    end
    else
    begin
      tamper_seen <= tamper_erase_in |
                     (tamper_seen & ~(wr_en & hit_st & pwdata[sbs_pkg::ST_TAMPER]));
      loader_seen <= loader_fall |
                     (loader_seen & ~(wr_en & hit_st & pwdata[sbs_pkg::ST_LOADER]));
    end
  end

  // Power pins; the reset line is open drain, so only the enable moves
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      power_reset_out <= 1'b0;
      power_reset_oe  <= 1'b0;
      core_reset_n    <= 1'b0;
      backup_active_n <= 1'b1;
      loader_start    <= 1'b0;
    end
    else
    begin
      power_reset_out <= 1'b0;
      power_reset_oe  <= vcc_low; // RULE11
      core_reset_n    <= ~rst_req; // RULE12
      backup_active_n <= ~vcc_backup; // RULE13
      loader_start    <= loader_fall; // RULE9
    end
  end

  // Backed supply stays off after a tamper event until full reset
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      vcco_enable <= 1'b1;
    else if (tamper_erase_in)
      vcco_enable <= 1'b0; // RULE15
  end

  // Request stage feeding the decoder; dropped while the core is held
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      req_q <= '0;
    else
    begin
      req_q       <= mem_req;
      req_q.valid <= mem_req.valid & ~rst_req;
    end
  end

  // Selects; backed pins forced high in backup, unbacked ones are not
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ram_select_a          <= 1'b1;
      ram_select_b          <= 1'b1;
      ram_select_c          <= 1'b1;
      ram_select_d          <= 1'b1;
      ram_select_a_unbacked <= 1'b1;
      periph_select_0       <= 1'b1;
      periph_select_1       <= 1'b1;
      periph_select_2       <= 1'b1;
      periph_select_3       <= 1'b1;
      mem_write_n           <= 1'b1;
    end
    else
    begin
      ram_select_a          <= sel.ram_n[0] | hold_high; // RULE4 RULE24
      ram_select_b          <= sel.ram_n[1] | hold_high; // RULE3
      ram_select_c          <= sel.ram_n[2] | hold_high; // RULE2
      ram_select_d          <= sel.ram_n[3] | hold_high; // RULE1
      ram_select_a_unbacked <= sel.ram_n[0]; // RULE18
      periph_select_0       <= sel.periph_n[0] | hold_high;
      periph_select_1       <= sel.periph_n[1] | hold_high;
      periph_select_2       <= sel.periph_n[2];
      periph_select_3       <= sel.periph_n[3];
      mem_write_n           <= sel.wr_n | hold_high;
    end
  end

  // Address and data; data is masked with the key byte picked by address
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      byte_bus_addr     <= '0;
      byte_bus_data_out <= 8'h00;
      byte_bus_data_oe  <= 1'b0;
      rd_pending        <= 1'b0;
      rd_key_idx        <= 3'h0;
    end
    else
    begin
      if (req_q.valid)
        byte_bus_addr <= req_q.addr[sbs_pkg::BUS_AW-1:0];
      byte_bus_data_out <= req_q.wdata ^ sbs_pkg::key_byte(key, req_q.addr[2:0]); // RULE19
      byte_bus_data_oe  <= req_q.valid & req_q.write & ~hold_high;
      rd_pending        <= req_q.valid & ~req_q.write;
      rd_key_idx        <= req_q.addr[2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      mem_rdata <= 8'h00;
    else if (rd_pending)
      mem_rdata <= byte_bus_data_in ^ sbs_pkg::key_byte(key, rd_key_idx); // RULE19
  end

endmodule

// ==== test/sbs_bus_select_asserts.sv ====
/*
  Pin-level assertions for the secure byte-wide bus select block.
  Assumes one clock domain and selects shown two cycles after a request.
*/
`timescale 1ns/10ps
module sbs_bus_select_asserts
(
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  nrst,
  // Requests
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pready,
  input wire sbs_pkg::sbs_mem_req_s mem_req,
  // Selects
  input wire logic                  mem_write_n,
  input wire logic                  ram_select_a,
  input wire logic                  ram_select_b,
  input wire logic                  ram_select_c,
  input wire logic                  ram_select_d,
  input wire logic                  ram_select_a_unbacked,
  input wire logic                  periph_select_0,
  input wire logic                  periph_select_1,
  input wire logic                  periph_select_2,
  input wire logic                  periph_select_3,
  // Power and security
  input wire logic                  vcc_low,
  input wire logic                  vcc_backup,
  input wire logic                  power_reset_in,
  input wire logic                  power_reset_oe,
  input wire logic                  core_reset_n,
  input wire logic                  backup_active_n,
  input wire logic                  vcco_enable,
  input wire logic                  sram_size_sel,
  input wire logic                  loader_trigger_n,
  input wire logic                  loader_start,
  input wire logic                  tamper_erase_in
);
  logic [3:0] ce;
  logic [3:0] pe;
  logic       ok;
  assign ce = {ram_select_d, ram_select_c, ram_select_b, ram_select_a};
  assign pe = {periph_select_3, periph_select_2, periph_select_1, periph_select_0};
  // Requests are dropped in reset and backed selects held high in backup, so only quiet windows count
  assign ok = !vcc_backup && !vcc_low && power_reset_in;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence ram_req(logic m);
    mem_req.valid && !mem_req.data_space && ok && sram_size_sel == m
    ##1 ok && sram_size_sel == m ##1 ok && sram_size_sel == m;
  endsequence

  chk_block_32k: assert property (
    ram_req(1'b1) |-> ce == ~(4'h1 << $past(mem_req.addr[16:15], 2)))
    else $error("32k block select wrong");
  chk_split_128k: assert property (
    ram_req(1'b0) |-> !ram_select_a && ram_select_d
      && ram_select_b == $past(mem_req.addr[16], 2)
      && ram_select_c == $past(mem_req.addr[15], 2))
    else $error("128k address selects wrong");
  chk_backed_high: assert property (
    vcc_backup [*3] |-> ce == 4'hF && periph_select_0 && periph_select_1 && mem_write_n)
    else $error("backed select active in backup");
  chk_periph_sel: assert property (
    pe != 4'hF |-> $past(mem_req.valid && mem_req.data_space, 2)
      && pe == ~(4'h1 << $past(mem_req.addr[15:14], 2)))
    else $error("peripheral select wrong");
  chk_unbacked_copy: assert property (
    !vcc_backup [*3] |-> ram_select_a_unbacked == ram_select_a)
    else $error("unbacked copy differs");
  chk_power_pins: assert property (
    nrst |=> backup_active_n != $past(vcc_backup) && power_reset_oe == $past(vcc_low))
    else $error("power pins wrong");
  chk_core_reset: assert property (
    nrst |=> core_reset_n == !($past(vcc_low) || !$past(power_reset_in)))
    else $error("core reset wrong");
  chk_loader_pulse: assert property (
    $fell(loader_trigger_n) |-> ##[0:2] loader_start)
    else $error("loader start missing");
  chk_tamper_power: assert property (
    tamper_erase_in |-> ##[1:2] !vcco_enable)
    else $error("backed supply not removed");
  chk_apb_answer: assert property (
    psel && penable && !pready |=> pready)
    else $error("apb answer late");
  chk_ready_pulse: assert property (
    pready |=> !pready)
    else $error("pready too long");
endmodule

bind sbs_bus_select sbs_bus_select_asserts i_sbs_bus_select_asserts
  (.clk_sys, .nrst, .psel, .penable, .pready, .mem_req, .mem_write_n, .ram_select_a,
   .ram_select_b, .ram_select_c, .ram_select_d, .ram_select_a_unbacked, .periph_select_0,
   .periph_select_1, .periph_select_2, .periph_select_3, .vcc_low, .vcc_backup,
   .power_reset_in, .power_reset_oe, .core_reset_n, .backup_active_n, .vcco_enable,
   .sram_size_sel, .loader_trigger_n, .loader_start, .tamper_erase_in);

// ==== test/sbs_sram_model.sv ====
/*
  External SRAM bank: four 32k parts or one 128k part.
  Assumes active-low selects; a released data bus shows the inverse of its last value.
*/
`timescale 1ns/10ps
module sbs_sram_model
(
  // Clock
  input wire logic        clk_sys,
  // Pins
  input wire logic        size_sel,
  input wire logic [14:0] addr,
  input wire logic [3:0]  sel_n,
  input wire logic        write_n,
  input wire logic [7:0]  wdata,
  output logic [7:0]      rdata
);
  logic [7:0] mem [0:131071];
  logic [7:0] last;
  logic [1:0] blk;
  logic       hit;
  assign hit = size_sel ? (sel_n != 4'hF) : !sel_n[0];
  assign blk = size_sel ? (!sel_n[1] ? 2'h1 : !sel_n[2] ? 2'h2 : !sel_n[3] ? 2'h3 : 2'h0)
                        : {sel_n[1], sel_n[2]};
  assign rdata = (hit && write_n) ? mem[{blk, addr}] : ~last;
  always @(posedge clk_sys)
  begin
    if (hit && !write_n)
      mem[{blk, addr}] <= wdata;
    last <= rdata;
  end
endmodule

// ==== test/testbench.sv ====
/*
  Self-checking testbench for the secure byte-wide bus select block.
  Assumes one APB wait state and selects shown two cycles after a request.
*/
`timescale 1ns/10ps
`define CHK(n, e, s) \
  begin \
    comparisons++; \
    if ((s) !== (e)) \
    begin \
      $display("wrong value %s exp %h got %h", n, e, s); \
      errors++; \
    end \
  end
module testbench;
  logic                  clk_sys, nrst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]            paddr, mem_rdata, byte_bus_data_out, byte_bus_data_in;
  logic [31:0]           pwdata, prdata, rd;
  sbs_pkg::sbs_mem_req_s mem_req;
  logic [14:0]           byte_bus_addr;
  logic                  byte_bus_data_oe, mem_write_n, ram_select_a, ram_select_b;
  logic                  ram_select_c, ram_select_d, ram_select_a_unbacked;
  logic                  periph_select_0, periph_select_1, periph_select_2, periph_select_3;
  logic                  vcc_low, vcc_backup, power_reset_in, power_reset_oe, core_reset_n;
  logic                  backup_active_n, vcco_enable, sram_size_sel, loader_trigger_n;
  logic                  loader_start, tamper_erase_in, trng_valid, ext_rst, power_reset_out;
  logic [63:0]           trng_data;
  logic [3:0]            ce, pe;
  int                    errors, comparisons, starts, k;
  assign ce = {ram_select_d, ram_select_c, ram_select_b, ram_select_a};
  assign pe = {periph_select_3, periph_select_2, periph_select_1, periph_select_0};
  // Open-drain wire with pull-up: low if either party pulls
  assign power_reset_in = !(power_reset_oe || ext_rst);

  sbs_bus_select i_sbs_bus_select (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .mem_req, .mem_rdata, .byte_bus_addr,
    .byte_bus_data_out, .byte_bus_data_oe, .byte_bus_data_in, .mem_write_n, .ram_select_a,
    .ram_select_b, .ram_select_c, .ram_select_d, .ram_select_a_unbacked, .periph_select_0,
    .periph_select_1, .periph_select_2, .periph_select_3, .vcc_low, .vcc_backup,
    .power_reset_in, .power_reset_out, .power_reset_oe, .core_reset_n, .backup_active_n,
    .vcco_enable, .sram_size_sel, .loader_trigger_n, .loader_start, .tamper_erase_in,
    .trng_data, .trng_valid);
  sbs_sram_model i_sbs_sram_model (.clk_sys, .size_sel(sram_size_sel), .addr(byte_bus_addr),
    .sel_n(ce), .write_n(mem_write_n), .wdata(byte_bus_data_out), .rdata(byte_bus_data_in));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
    if (loader_start === 1'b1)
      starts++;

  task automatic results;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Read data and error are taken where pready is high, before that edge releases
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Returns on the edge closing the select cycle, so reads see its values
  task automatic mem(input logic ds, w, input logic [16:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    mem_req <= '{1'b1, ds, w, a, d};
    @(posedge clk_sys);
    mem_req.valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  initial
  begin
    #50000;
    errors++;
    results();
  end

  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata, mem_req} = '0;
    {vcc_low, vcc_backup, ext_rst, tamper_erase_in, trng_valid} = '0;
    {sram_size_sel, loader_trigger_n} = 2'h3;
    trng_data = 64'h8877665544332211;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    apb(0, sbs_pkg::OFF_CTRL, 0);
    `CHK("ctrl", 32'h0, rd)
    apb(0, 8'h40, 0);
    `CHK("slverr", 1'b1, er)
    apb(0, sbs_pkg::OFF_STATUS, 0);
    `CHK("size", 1'b1, rd[sbs_pkg::ST_SIZE])
    for (k = 0; k < 4; k++)
    begin
      mem(0, 0, {k[1:0], 15'h1234}, 0);
      `CHK("ce32", ~(4'h1 << k), ce)
      `CHK("addr", 15'h1234, byte_bus_addr)
    end
    sram_size_sel <= 1'b0;
    for (k = 0; k < 4; k++)
    begin
      mem(0, 0, {k[1:0], 15'h0}, 0);
      `CHK("ce128", {1'b1, k[0], k[1], 1'b0}, ce)
    end
    sram_size_sel <= 1'b1;
    apb(1, sbs_pkg::OFF_CTRL, 1);
    for (k = 0; k < 8; k++)
    begin
      mem(1, 0, {1'b0, k[2:1], k[0] ? 14'h3FFF : 14'h0}, 0);
      `CHK("pe", ~(4'h1 << k[2:1]), pe)
      `CHK("ce off", 4'hF, ce)
    end
    apb(1, sbs_pkg::OFF_CTRL, 0);
    mem(1, 0, 17'h0C000, 0);
    `CHK("pe off", 4'hF, pe)
    `CHK("ce data", 4'hD, ce)
    trng_valid <= 1'b1;
    apb(1, sbs_pkg::OFF_CTRL, 4);
    apb(0, sbs_pkg::OFF_STATUS, 0);
    `CHK("key", 2'h1, rd[3:2])
    apb(1, sbs_pkg::OFF_CTRL, 32'h100);
    mem(0, 1, 17'h00402, 8'h5A);
    `CHK("wr", 2'h1, {mem_write_n, byte_bus_data_oe})
    `CHK("cipher", 8'h69, byte_bus_data_out)
    mem(0, 0, 17'h00402, 0);
    @(posedge clk_sys);
    `CHK("plain", 8'h5A, mem_rdata)
    mem(0, 1, 17'h00010, 8'hA5);
    `CHK("wp", 1'b1, mem_write_n)
    apb(0, sbs_pkg::OFF_KEY, 0);
    `CHK("keyrd", 32'h0, rd)
    apb(0, sbs_pkg::OFF_STATUS, 0);
    `CHK("keygone", 2'h0, rd[3:2])
    vcc_backup <= 1'b1;
    mem(0, 0, 17'h0, 0);
    `CHK("bk", 1'b0, backup_active_n)
    `CHK("ce bk", 4'hF, ce)
    `CHK("unbk", 1'b0, ram_select_a_unbacked)
    vcc_backup <= 1'b0;
    starts = 0;
    loader_trigger_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    `CHK("loader", 1, starts)
    loader_trigger_n <= 1'b1;
    apb(1, sbs_pkg::OFF_CTRL, 4);
    apb(1, sbs_pkg::OFF_VIDX, 47);
    apb(1, sbs_pkg::OFF_VDATA, 32'hC3);
    apb(0, sbs_pkg::OFF_VDATA, 0);
    `CHK("vec", 32'hC3, rd)
    tamper_erase_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    tamper_erase_in <= 1'b0;
    `CHK("vcco", 1'b0, vcco_enable)
    apb(0, sbs_pkg::OFF_VDATA, 0);
    `CHK("vec erased", 32'h0, rd)
    apb(0, sbs_pkg::OFF_STATUS, 0);
    `CHK("tamper", 3'h4, rd[4:2])
    vcc_low <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK("power_reset_io", 4'h8, {power_reset_oe, power_reset_out, power_reset_in, core_reset_n})
    vcc_low <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHK("run", 1'b1, core_reset_n)
    ext_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK("ext", 1'b0, core_reset_n)
    ext_rst <= 1'b0;
    results();
  end
endmodule
